// ### dma_count_and_status.sv
// Function
// - each channel counts blocks of programmed count plus one transfers, 10-bit count
// - count register bits 15..10 always read zero
// - peripheral write collision flags in collision bits 15..8, channel 0 at bit 8
// - buffer ram write collision flags in collision bits 7..0, channel 0 at bit 0
// - collision flags reset to zero, sticky, software may only clear them
// - status bits 11..8 show last channel that transferred; 15..12 reserved
// - status bits 7..0 show per-channel ping-pong buffer, 1 means secondary
// - last buffer address register captures most recent ram address, resets zero
// - mode 11 one-shot ping-pong, mode 10 continuous ping-pong
// - start address reads return the live address counter
`timescale 1ns/1ps
`default_nettype none
module dma_count_and_status
  import dma_status_pkg::*;
(
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RSTN,
  // register port
  input  wire logic [4:0]  ADDR,
  input  wire logic [15:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [15:0] RDATA,
  // transfer engine events
  input  wire logic [7:0]  XFER_DONE,
  input  wire logic [7:0]  PERIPH_COLLISION,
  input  wire logic [7:0]  RAM_COLLISION,
  // engine side
  output logic      [7:0]  CHANNEL_ENABLE,
  output logic      [15:0] RAM_ADDR,
  output logic      [7:0]  BLOCK_DONE,
  // interrupt
  output logic             IRQ
);
  // =========================================
  // storage
  logic [COUNT_W-1:0] count_reg [NUM_CH];
  logic [COUNT_W-1:0] done_reg  [NUM_CH];
  logic [15:0]        start_a_reg [NUM_CH];
  logic [15:0]        start_b_reg [NUM_CH];
  logic [15:0]        addr_reg  [NUM_CH];
  logic [1:0]         mode_reg  [NUM_CH];
  logic [7:0]         enable_reg;
  logic [7:0]         pingpong_state_reg;
  logic [7:0]         periph_write_collision_reg;
  logic [7:0]         ram_write_collision_reg;
  logic [3:0]         last_channel_reg;
  logic [15:0]        last_buffer_address_reg;
  logic [1:0]         irq_status_reg;
  logic [1:0]         irq_mask_reg;
  logic [7:0]         block_end;
  logic [2:0]         xfer_ch;
  logic               xfer_any;
  logic [15:0]        rdata_next;

  function automatic logic is_pingpong(input logic [1:0] m);
    return (m == MODE_CONT_PP) || (m == MODE_ONESHOT_PP);
  endfunction : is_pingpong

  // =========================================
  // transfer selection: lowest numbered enabled channel wins
  always_comb begin
    xfer_any = 1'b0;
    xfer_ch  = 3'h0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (XFER_DONE[i] && enable_reg[i]) begin
        xfer_any = 1'b1;
        xfer_ch  = 3'(i);
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      block_end[i] = xfer_any && (xfer_ch == 3'(i)) && (done_reg[i] == count_reg[i]);
    end
  end

  // =========================================
  // per-channel counters and addresses
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      for (int i = 0; i < NUM_CH; i++) begin
        count_reg[i]   <= '0;
        done_reg[i]    <= '0;
        start_a_reg[i] <= RESET_WORD;
        start_b_reg[i] <= RESET_WORD;
        addr_reg[i]    <= RESET_WORD;
        mode_reg[i]    <= 2'h0;
      end
      enable_reg         <= 8'h00;
      pingpong_state_reg <= 8'h00;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (WR && ADDR == OFS_COUNT0 + 5'(i)) begin
          count_reg[i] <= WDATA[COUNT_W-1:0];
        end
        if (WR && ADDR == OFS_PRIMARY0 + 5'(2*i)) begin
          start_a_reg[i] <= WDATA;
          if (!enable_reg[i] && !pingpong_state_reg[i]) begin
            addr_reg[i] <= WDATA;
          end
        end
        if (WR && ADDR == OFS_PRIMARY0 + 5'(2*i+1)) begin
          start_b_reg[i] <= WDATA;
          if (!enable_reg[i] && pingpong_state_reg[i]) begin
            addr_reg[i] <= WDATA;
          end
        end
        if (WR && ADDR == OFS_MODE) begin
          mode_reg[i] <= WDATA[2*i +: 2];
        end
        if (xfer_any && xfer_ch == 3'(i)) begin
          if (block_end[i]) begin
            done_reg[i] <= '0;
            if (is_pingpong(mode_reg[i])) begin
              pingpong_state_reg[i] <= ~pingpong_state_reg[i];
              addr_reg[i] <= pingpong_state_reg[i] ? start_a_reg[i] : start_b_reg[i];
            end else begin
              addr_reg[i] <= start_a_reg[i];
            end
          end else begin
            done_reg[i] <= done_reg[i] + 1'b1;
            addr_reg[i] <= addr_reg[i] + 16'h0001;
          end
        end
      end
      if (WR && ADDR == OFS_ENABLE) begin
        enable_reg <= WDATA[7:0];
      end else begin
        for (int i = 0; i < NUM_CH; i++) begin
          // one-shot ping-pong stops after the secondary block, one-shot after any block
          if (block_end[i] && mode_reg[i] != MODE_CONT_PP &&
              !(mode_reg[i] == MODE_ONESHOT_PP && !pingpong_state_reg[i])) begin
            enable_reg[i] <= 1'b0;
          end
        end
      end
    end
  end

  // =========================================
  // controller status
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      periph_write_collision_reg <= 8'h00;
      ram_write_collision_reg    <= 8'h00;
    end else begin
      // set wins over a same-cycle clear
      periph_write_collision_reg <= (periph_write_collision_reg
        & ~((WR && ADDR == OFS_COLLISION) ? WDATA[15:8] : 8'h00)) | PERIPH_COLLISION;
      ram_write_collision_reg <= (ram_write_collision_reg
        & ~((WR && ADDR == OFS_COLLISION) ? WDATA[7:0] : 8'h00)) | RAM_COLLISION;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      last_channel_reg        <= LAST_CH_NONE;
      last_buffer_address_reg <= RESET_WORD;
    end else if (xfer_any) begin
      last_channel_reg        <= {1'b0, xfer_ch};
      last_buffer_address_reg <= addr_reg[xfer_ch];
    end
  end

  // =========================================
  // interrupt: bit 0 collision, bit 1 block end
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      irq_status_reg <= 2'h0;
      irq_mask_reg   <= 2'h0;
    end else begin
      irq_status_reg <= (irq_status_reg & ~((WR && ADDR == OFS_IRQ_STATUS) ? WDATA[1:0] : 2'h0))
        | {|block_end, |(PERIPH_COLLISION | RAM_COLLISION)};
      if (WR && ADDR == OFS_IRQ_MASK) begin
        irq_mask_reg <= WDATA[1:0];
      end
    end
  end

  assign IRQ            = |(irq_status_reg & irq_mask_reg);
  assign CHANNEL_ENABLE = enable_reg;
  assign RAM_ADDR       = last_buffer_address_reg;
  assign BLOCK_DONE     = block_end;

  // =========================================
  // read port
  always_comb begin
    rdata_next = 16'h0000;
    if (ADDR < OFS_PRIMARY0) begin
      rdata_next = {6'h00, count_reg[ADDR[2:0]]};
    end else if (ADDR < OFS_COLLISION) begin
      rdata_next = addr_reg[3'((ADDR - OFS_PRIMARY0) >> 1)];
    end else begin
      unique case (ADDR)
        OFS_COLLISION:  rdata_next = {periph_write_collision_reg, ram_write_collision_reg};
        OFS_CH_STATUS:  rdata_next = {4'h0, last_channel_reg, pingpong_state_reg};
        OFS_LAST_ADDR:  rdata_next = last_buffer_address_reg;
        OFS_MODE:       rdata_next = {mode_reg[7], mode_reg[6], mode_reg[5], mode_reg[4],
                                      mode_reg[3], mode_reg[2], mode_reg[1], mode_reg[0]};
        OFS_ENABLE:     rdata_next = {8'h00, enable_reg};
        OFS_IRQ_STATUS: rdata_next = {14'h0000, irq_status_reg};
        OFS_IRQ_MASK:   rdata_next = {14'h0000, irq_mask_reg};
        default:        rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      RDATA <= 16'h0000;
    end else begin
      RDATA <= RD ? rdata_next : 16'h0000;
    end
  end

  // =========================================
  // checks
  sequence ch2_step;
    xfer_any && xfer_ch == 3'h2 && !block_end[2];
  endsequence
  sequence ch2_end;
    xfer_any && xfer_ch == 3'h2 && block_end[2];
  endsequence

  a_count_step: assert property (@(posedge CLK) disable iff (!RSTN)
    ch2_step |=> done_reg[2] == $past(done_reg[2]) + 10'h001)
    else $error("transfer count did not advance");
  a_disabled_ignored: assert property (@(posedge CLK) disable iff (!RSTN)
    !enable_reg[2] |=> $stable(done_reg[2]))
    else $error("disabled channel counted a transfer");
  a_count_read: assert property (@(posedge CLK) disable iff (!RSTN)
    RD && ADDR == OFS_COUNT0 + 5'h3 |=> RDATA[9:0] == $past(count_reg[3]))
    else $error("count read wrong");
  a_oneshot_stop: assert property (@(posedge CLK) disable iff (!RSTN)
    block_end[2] && mode_reg[2] == MODE_ONESHOT_PP && pingpong_state_reg[2]
    && !(WR && ADDR == OFS_ENABLE) |=> !enable_reg[2])
    else $error("one-shot ping-pong channel not stopped");
  a_cont_keeps: assert property (@(posedge CLK) disable iff (!RSTN)
    block_end[5] && mode_reg[5] == MODE_CONT_PP && !(WR && ADDR == OFS_ENABLE) |=> enable_reg[5])
    else $error("continuous channel stopped");
  a_live_addr_read: assert property (@(posedge CLK) disable iff (!RSTN)
    RD && ADDR == OFS_PRIMARY0 + 5'h5 |=> RDATA == $past(addr_reg[2]))
    else $error("start address read not live");
  a_ram_sticky: assert property (@(posedge CLK) disable iff (!RSTN)
    $past(ram_write_collision_reg[7]) && !$past(WR) |-> ram_write_collision_reg[7])
    else $error("ram collision flag dropped without a clear");
  a_periph_clear: assert property (@(posedge CLK) disable iff (!RSTN)
    WR && ADDR == OFS_COLLISION && WDATA[8] && !PERIPH_COLLISION[0] |=> !periph_write_collision_reg[0])
    else $error("collision flag not cleared");
  a_last_ch_range: assert property (@(posedge CLK) disable iff (!RSTN)
    last_channel_reg[3] |-> last_channel_reg == LAST_CH_NONE)
    else $error("reserved last channel code");
  a_last_ch_hold: assert property (@(posedge CLK) disable iff (!RSTN)
    !xfer_any |=> $stable(last_channel_reg))
    else $error("last channel moved without a transfer");
  a_status_read: assert property (@(posedge CLK) disable iff (!RSTN)
    RD && ADDR == OFS_CH_STATUS |=> RDATA[7:0] == $past(pingpong_state_reg))
    else $error("ping-pong status read wrong");
  a_pp_hold: assert property (@(posedge CLK) disable iff (!RSTN)
    !block_end[5] |=> $stable(pingpong_state_reg[5]))
    else $error("ping-pong state moved without a block end");
  a_last_addr_hold: assert property (@(posedge CLK) disable iff (!RSTN)
    !xfer_any |=> $stable(last_buffer_address_reg))
    else $error("last buffer address moved without a transfer");
  a_collision_sticky: assert property (@(posedge CLK) disable iff (!RSTN)
    $past(periph_write_collision_reg[0]) && !$past(WR) |-> periph_write_collision_reg[0])
    else $error("collision flag dropped without a clear");
  a_collision_sets: assert property (@(posedge CLK) disable iff (!RSTN)
    RAM_COLLISION[3] |=> ram_write_collision_reg[3])
    else $error("ram collision flag not set");
  a_periph_sets: assert property (@(posedge CLK) disable iff (!RSTN)
    PERIPH_COLLISION[7] |=> RD && ADDR == OFS_COLLISION |=> RDATA[15])
    else $error("peripheral collision flag not visible");
  a_count_upper_zero: assert property (@(posedge CLK) disable iff (!RSTN)
    RD && ADDR < OFS_PRIMARY0 |=> RDATA[15:10] == 6'h00)
    else $error("count upper bits not zero");
  a_status_upper_zero: assert property (@(posedge CLK) disable iff (!RSTN)
    RD && ADDR == OFS_CH_STATUS |=> RDATA[15:12] == 4'h0)
    else $error("status upper bits not zero");
  a_last_channel: assert property (@(posedge CLK) disable iff (!RSTN)
    xfer_any |=> last_channel_reg == {1'b0, $past(xfer_ch)})
    else $error("last channel wrong");
  a_pingpong_flip: assert property (@(posedge CLK) disable iff (!RSTN)
    block_end[2] && is_pingpong(mode_reg[2]) |=> pingpong_state_reg[2] != $past(pingpong_state_reg[2]))
    else $error("ping-pong state did not toggle");
  a_last_addr: assert property (@(posedge CLK) disable iff (!RSTN)
    xfer_any |=> last_buffer_address_reg == $past(addr_reg[xfer_ch]))
    else $error("last buffer address not captured");
  a_block_length: assert property (@(posedge CLK) disable iff (!RSTN)
    ch2_end |=> done_reg[2] == 10'h000)
    else $error("block count not restarted");
endmodule : dma_count_and_status
`default_nettype wire

// ### dma_status_pkg.sv
package dma_status_pkg;
  // =========================================
  // geometry
  localparam int          NUM_CH          = 8;
  localparam int          COUNT_W         = 10;
  // =========================================
  // register offsets (word index on the plain port)
  localparam logic [4:0]  OFS_COUNT0      = 5'h00;  // eight count registers 00..07
  localparam logic [4:0]  OFS_PRIMARY0    = 5'h08;  // eight start address pairs 08..17
  localparam logic [4:0]  OFS_COLLISION   = 5'h18;
  localparam logic [4:0]  OFS_CH_STATUS   = 5'h19;
  localparam logic [4:0]  OFS_LAST_ADDR   = 5'h1A;
  localparam logic [4:0]  OFS_MODE        = 5'h1B;
  localparam logic [4:0]  OFS_ENABLE      = 5'h1C;
  localparam logic [4:0]  OFS_IRQ_STATUS  = 5'h1D;
  localparam logic [4:0]  OFS_IRQ_MASK    = 5'h1E;
  // =========================================
  // field positions and reset values
  localparam int          PERIPH_COL_LSB  = 8;
  localparam int          LAST_CH_LSB     = 8;
  localparam logic [3:0]  LAST_CH_NONE    = 4'hF;
  localparam logic [1:0]  MODE_CONT_PP    = 2'h2;
  localparam logic [1:0]  MODE_ONESHOT_PP = 2'h3;
  localparam logic [15:0] RESET_WORD      = 16'h0000;
endpackage : dma_status_pkg

// ### xfer_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
module xfer_engine_model (
  // clock
  input  wire logic       clk,
  // engine events
  output logic      [7:0] xfer_done,
  output logic      [7:0] periph_collision,
  output logic      [7:0] ram_collision
);
  initial begin
    xfer_done        = 8'h00;
    periph_collision = 8'h00;
    ram_collision    = 8'h00;
  end

  // =========================================
  // n transfers on one channel, back to back or spaced
  task automatic burst(input int ch, input int n, input bit slow);
    for (int i = 0; i < n; i++) begin
      xfer_done <= 8'h01 << ch;
      @(posedge clk);
      if (slow || i == n - 1) begin
        xfer_done <= 8'h00;
        @(posedge clk);
      end
    end
  endtask : burst

  // =========================================
  // one-cycle collision report
  task automatic collide(input logic [7:0] p, input logic [7:0] r);
    periph_collision <= p;
    ram_collision    <= r;
    @(posedge clk);
    periph_collision <= 8'h00;
    ram_collision    <= 8'h00;
  endtask : collide
endmodule : xfer_engine_model
`default_nettype wire

// ### testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dma_status_pkg::*;
  logic        clk, rstn, wr, rd, irq;
  logic [4:0]  addr;
  logic [15:0] wdata, rdata, ram_addr;
  logic [7:0]  xfer, pcol, rcol, ch_en, blk;
  int          error_cnt, checks, blocks;

  dma_count_and_status dut_u (.CLK(clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .XFER_DONE(xfer), .PERIPH_COLLISION(pcol),
    .RAM_COLLISION(rcol), .CHANNEL_ENABLE(ch_en), .RAM_ADDR(ram_addr),
    .BLOCK_DONE(blk), .IRQ(irq));
  xfer_engine_model model_u (.clk(clk), .xfer_done(xfer), .periph_collision(pcol),
    .ram_collision(rcol));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) if (|blk) blocks <= blocks + 1;

  // =========================================
  // checks and bus tasks
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wr_reg
  task automatic rchk(input logic [4:0] a, input logic [15:0] exp);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk($sformatf("reg %h", a), rdata, exp);
    @(posedge clk);
  endtask : rchk
  task automatic print_verdict;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    print_verdict();
  end

  // =========================================
  // main sequence
  initial begin
    rstn = 1'b0; wr = 1'b0; rd = 1'b0; addr = 5'h00; wdata = 16'h0000;
    blocks = 0; error_cnt = 0; checks = 0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rchk(OFS_COLLISION, RESET_WORD);
    rchk(OFS_CH_STATUS, {4'h0, LAST_CH_NONE, 8'h00});
    rchk(OFS_LAST_ADDR, RESET_WORD);
    rchk(5'h1F, 16'h0000);
    wr_reg(OFS_COUNT0 + 5'h3, 16'hFFFF);
    rchk(OFS_COUNT0 + 5'h3, 16'h03FF);
    model_u.collide(8'h01, 8'h80);
    rchk(OFS_COLLISION, 16'h0180);
    chk("irq masked", {15'h0, irq}, 16'h0000);
    wr_reg(OFS_IRQ_MASK, 16'h0001);
    chk("irq", {15'h0, irq}, 16'h0001);
    wr_reg(OFS_COLLISION, 16'h0100);
    rchk(OFS_COLLISION, 16'h0080);
    wr_reg(OFS_COLLISION, 16'h0080);
    wr_reg(OFS_IRQ_STATUS, 16'h0001);
    chk("irq cleared", {15'h0, irq}, 16'h0000);
    // counts written while channels are disabled
    wr_reg(OFS_COUNT0 + 5'h2, 16'h0001);
    wr_reg(OFS_COUNT0 + 5'h5, 16'h0000);
    wr_reg(OFS_PRIMARY0 + 5'h4, 16'h0100);
    wr_reg(OFS_PRIMARY0 + 5'h5, 16'h0200);
    wr_reg(OFS_MODE, 16'h0830);
    wr_reg(OFS_IRQ_MASK, 16'h0002);
    wr_reg(OFS_ENABLE, 16'h0024);
    model_u.burst(2, 2, 1'b0);
    repeat (2) @(posedge clk);
    chk("blocks", 16'(blocks), 16'h0001);
    chk("irq block", {15'h0, irq}, 16'h0001);
    rchk(OFS_CH_STATUS, 16'h0204);
    rchk(OFS_LAST_ADDR, 16'h0101);
    rchk(OFS_PRIMARY0 + 5'h5, 16'h0200);
    rchk(OFS_ENABLE, 16'h0024);
    model_u.burst(2, 2, 1'b1);
    rchk(OFS_CH_STATUS, 16'h0200);
    rchk(OFS_ENABLE, 16'h0020);
    rchk(OFS_LAST_ADDR, 16'h0201);
    chk("ram addr", ram_addr, 16'h0201);
    model_u.burst(5, 3, 1'b0);
    model_u.burst(2, 1, 1'b0);
    repeat (2) @(posedge clk);
    chk("blocks", 16'(blocks), 16'h0005);
    rchk(OFS_CH_STATUS, 16'h0520);
    rchk(OFS_ENABLE, 16'h0020);
    chk("enable pins", {8'h00, ch_en}, 16'h0020);
    model_u.collide(8'h80, 8'h08);
    rchk(OFS_COLLISION, 16'h8008);
    wr_reg(OFS_IRQ_STATUS, 16'h0002);
    chk("irq end", {15'h0, irq}, 16'h0000);
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
